// file: seb_eeprom_slave.sv
/*
 * Two-wire slave front end and byte array of a 32768-byte serial memory.
 * Assumes an external pull-up on the data line and pull-downs on the select straps.
 */
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Data changes while clock is high are start or stop, never data.
// - Start is data falling with clock high; nothing is answered before one.
// - Stop is data rising with clock high and ends every operation.
// - Address byte: type pattern 10100, two select bits, direction bit last.
// - Select bits must equal the two strap inputs; four devices per bus.
// - Direction bit one means read, zero means write.
// - Receiver of eight bits pulls data low through the ninth clock.
// - Matching address acknowledged; in write both word address bytes acknowledged, data bytes only without write protect.
// - Read: send eight bits, sample master ack, continue or wait for stop.
// - Stop after write starts programming; device silent until it ends.
// - Master may poll with write address; ack only once programming finished.
// - Up to 64 data bytes accepted and programmed in one cycle.
// - Each written byte advances only the six low pointer bits.
// - More than 64 bytes wrap in the page and overwrite earlier ones.
// - Stop after page write programs all buffered bytes together.
// - Write protect: addresses acked, first data byte not, array untouched.
// - Pointer holds last location plus one; reads wrap from 32767 to 0, writes wrap within the page.
// - Each master ack advances the full pointer and sends another byte.
// - Programming ends within the cycle time; data line stays released.
// - Unconnected select straps count as zero.
module seb_eeprom_slave #(
   parameter int unsigned PROG_CYCLES = seb_pkg::PROG_CYCLES
) (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic scl,
   input  wire logic sda_i,
   input  wire logic wp,
   input  wire logic select_strap_low,
   input  wire logic select_strap_high,
   output var  logic sda_o,
   output var  logic sda_oe,
   output var  logic prog_busy
);

   ////////////////////////////////////////////////////////////////////////////////////////////////

   seb_bit_if link_bits ();

   seb_scl_sampler u_sampler (
      .scl   (scl),
      .rst_b (rst_b),
      .sda_i (sda_i),
      .bits  (link_bits.capture)
   );

   function automatic logic addr_match(input logic [7:0] b, input logic s_hi, input logic s_lo);
      return (b[7:3] == seb_pkg::DEV_TYPE) && (b[2] == s_hi) && (b[1] == s_lo);
   endfunction: addr_match

   ////////////////////////////////////////////////////////////////////////////////////////////////

   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic [1:0] wp_sync;
   logic [1:0] sel_lo_sync;
   logic [1:0] sel_hi_sync;
   logic [1:0] tog_sync;
   logic       scl_d;
   logic       sda_d;
   logic       tog_d;

   // Idle bus is high, so the line synchronisers reset high to avoid a false stop.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         scl_sync    <= 2'h3;
         sda_sync    <= 2'h3;
         wp_sync     <= 2'h0;
         sel_lo_sync <= 2'h0;
         sel_hi_sync <= 2'h0;
         tog_sync    <= 2'h0;
         scl_d       <= 1'h1;
         sda_d       <= 1'h1;
         tog_d       <= 1'h0;
      end else begin
         scl_sync    <= {scl_sync[0], scl};
         sda_sync    <= {sda_sync[0], sda_i};
         wp_sync     <= {wp_sync[0], wp};
         sel_lo_sync <= {sel_lo_sync[0], select_strap_low};
         sel_hi_sync <= {sel_hi_sync[0], select_strap_high};
         tog_sync    <= {tog_sync[0], link_bits.rise_toggle};
         scl_d       <= scl_sync[1];
         sda_d       <= sda_sync[1];
         tog_d       <= tog_sync[1];
      end
   end

   logic start_det;
   logic stop_det;
   logic fall_ev;
   logic rise_ev;

   assign start_det = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
   assign stop_det  = scl_sync[1] && scl_d && !sda_d && sda_sync[1];
   assign fall_ev   = scl_d && !scl_sync[1];
   assign rise_ev   = tog_sync[1] ^ tog_d;

   ////////////////////////////////////////////////////////////////////////////////////////////////

   seb_pkg::seb_state_t state;
   logic [3:0]          bit_cnt;
   logic [7:0]          shreg;
   logic                ack_en;
   logic                rd_dir;
   logic [14:0]         ptr;
   logic [7:0]          tx;
   logic [63:0]         page_valid;
   logic [8:0]          prog_page;
   logic [19:0]         prog_timer;
   logic [7:0]          page_buf [seb_pkg::PAGE_BYTES];
   logic [7:0]          mem      [seb_pkg::MEM_BYTES];

   logic       active;
   logic       byte_done;
   logic       ack_slot;
   logic       master_ack;
   logic       rd_load;
   logic       prog_done;
   logic [7:0] rx_full;
   logic       next_ack;
   logic [2:0] tx_idx;

   assign active     = (state != seb_pkg::SEB_IDLE) && (state != seb_pkg::SEB_WAIT_STOP);
   assign rx_full    = {shreg[6:0], link_bits.rise_bit};
   assign byte_done  = rise_ev && active && (bit_cnt == seb_pkg::LAST_DATA_BIT);
   assign ack_slot   = rise_ev && active && (bit_cnt == seb_pkg::ACK_BIT);
   assign master_ack = ack_slot && (state == seb_pkg::SEB_RD_DATA) && !link_bits.rise_bit;
   assign rd_load    = master_ack
                       || (ack_slot && (state == seb_pkg::SEB_DEV_ADDR) && ack_en && rd_dir);
   assign prog_done  = prog_busy && (prog_timer == 20'h00000);
   assign tx_idx     = 3'h7 - bit_cnt[2:0];

   // Strap synchronisers reset low and pads are pulled low, so open straps match zero.
   always_comb begin
      next_ack = 1'b0;
      if (state == seb_pkg::SEB_DEV_ADDR) begin
         next_ack = addr_match(rx_full, sel_hi_sync[1], sel_lo_sync[1]) && !prog_busy;
      end else if ((state == seb_pkg::SEB_ADDR_HI) || (state == seb_pkg::SEB_ADDR_LO)) begin
         next_ack = 1'b1;
      end else if (state == seb_pkg::SEB_WR_DATA) begin
         next_ack = !wp_sync[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= seb_pkg::SEB_IDLE;
      end else if (start_det) begin
         state <= seb_pkg::SEB_DEV_ADDR;
      end else if (stop_det) begin
         state <= seb_pkg::SEB_IDLE;
      end else if (ack_slot) begin
         unique case (state)
            seb_pkg::SEB_DEV_ADDR: begin
               if (!ack_en) begin
                  state <= seb_pkg::SEB_WAIT_STOP;
               end else if (rd_dir) begin
                  state <= seb_pkg::SEB_RD_DATA;
               end else begin
                  state <= seb_pkg::SEB_ADDR_HI;
               end
            end
            seb_pkg::SEB_ADDR_HI: begin
               state <= seb_pkg::SEB_ADDR_LO;
            end
            seb_pkg::SEB_ADDR_LO: begin
               state <= seb_pkg::SEB_WR_DATA;
            end
            seb_pkg::SEB_WR_DATA: begin
               state <= ack_en ? seb_pkg::SEB_WR_DATA : seb_pkg::SEB_WAIT_STOP;
            end
            seb_pkg::SEB_RD_DATA: begin
               state <= master_ack ? seb_pkg::SEB_RD_DATA : seb_pkg::SEB_WAIT_STOP;
            end
            seb_pkg::SEB_IDLE, seb_pkg::SEB_WAIT_STOP: begin
               state <= state;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt <= 4'h0;
         shreg   <= 8'h00;
         ack_en  <= 1'b0;
         rd_dir  <= 1'b0;
      end else if (start_det || stop_det) begin
         bit_cnt <= 4'h0;
         ack_en  <= 1'b0;
      end else if (rise_ev) begin
         shreg <= rx_full;
         if (active) begin
            bit_cnt <= (bit_cnt == seb_pkg::ACK_BIT) ? 4'h0 : bit_cnt + 4'h1;
         end
         if (byte_done) begin
            ack_en <= next_ack;
            if (state == seb_pkg::SEB_DEV_ADDR) begin
               rd_dir <= rx_full[0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ptr        <= seb_pkg::PTR_RESET;
         tx         <= 8'h00;
         page_valid <= 64'h0;
      end else begin
         if (prog_done || (start_det && !prog_busy)) begin
            page_valid <= 64'h0;
         end else if (byte_done && (state == seb_pkg::SEB_WR_DATA) && !wp_sync[1]) begin
            page_valid[ptr[5:0]] <= 1'b1;
         end
         if (byte_done && (state == seb_pkg::SEB_ADDR_HI)) begin
            ptr[14:8] <= rx_full[6:0];
         end else if (byte_done && (state == seb_pkg::SEB_ADDR_LO)) begin
            ptr[7:0] <= rx_full;
         end else if (byte_done && (state == seb_pkg::SEB_WR_DATA) && !wp_sync[1]) begin
            ptr[5:0] <= ptr[5:0] + 6'h01;
         end else if (rd_load) begin
            tx  <= mem[ptr];
            ptr <= ptr + 15'h0001;
         end
      end
   end

   // Array and page buffer are plain storage and need no reset.
   always_ff @(posedge clock) begin
      if (byte_done && (state == seb_pkg::SEB_WR_DATA) && !wp_sync[1]) begin
         page_buf[ptr[5:0]] <= rx_full;
      end
      if (prog_done) begin
         for (int i = 0; i < seb_pkg::PAGE_BYTES; i++) begin
            if (page_valid[i]) begin
               mem[{prog_page, 6'(i)}] <= page_buf[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////

   // Committing at the end of the cycle keeps reads of the page old until programming is over.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         prog_busy  <= 1'b0;
         prog_timer <= 20'h00000;
         prog_page  <= 9'h000;
      end else if (prog_busy) begin
         if (prog_done) begin
            prog_busy <= 1'b0;
         end else begin
            prog_timer <= prog_timer - 20'h00001;
         end
      end else if (stop_det && (state == seb_pkg::SEB_WR_DATA) && (|page_valid)) begin
         prog_busy  <= 1'b1;
         prog_timer <= 20'(PROG_CYCLES - 1);
         prog_page  <= ptr[14:6];
      end
   end

   // Open drain: a one is sent by releasing the line, a zero or an ack by driving it.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sda_oe <= 1'b0;
         sda_o  <= 1'b0;
      end else if (start_det || stop_det || prog_busy) begin
         sda_oe <= 1'b0;
      end else if (fall_ev) begin
         if ((state == seb_pkg::SEB_RD_DATA) && (bit_cnt < seb_pkg::ACK_BIT)) begin
            sda_oe <= !tx[tx_idx];
         end else begin
            sda_oe <= (bit_cnt == seb_pkg::ACK_BIT) && ack_en;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_busy_released: assert property (prog_busy |-> !sda_oe)
      else $error("data line driven during programming");

   a_start_resets: assert property (start_det |=> state == seb_pkg::SEB_DEV_ADDR && bit_cnt == 4'h0)
      else $error("start did not restart address reception");

   a_stop_idles: assert property (stop_det |=> state == seb_pkg::SEB_IDLE && !sda_oe)
      else $error("stop did not return to idle");

   a_prog_launch: assert property (stop_det && state == seb_pkg::SEB_WR_DATA && (|page_valid)
                                   && !prog_busy |=> prog_busy)
      else $error("write stop did not launch programming");

   a_prog_timer: assert property ($rose(prog_busy) |-> prog_timer == 20'(PROG_CYCLES - 1))
      else $error("program timer loaded with wrong count");

   a_prog_count: assert property (prog_busy && prog_timer != 20'h00000
                                  |=> prog_busy && prog_timer == $past(prog_timer) - 20'h00001)
      else $error("program timer did not count down");

   a_page_wrap: assert property (byte_done && state == seb_pkg::SEB_WR_DATA && !wp_sync[1]
                                 |=> ptr[14:6] == $past(ptr[14:6])
                                     && ptr[5:0] == $past(ptr[5:0]) + 6'h01)
      else $error("page write disturbed high pointer bits");

   a_read_step: assert property (master_ack |=> ptr == $past(ptr) + 15'h0001
                                 && state == seb_pkg::SEB_RD_DATA)
      else $error("master ack did not advance pointer");

   a_nack_waits: assert property (ack_slot && state == seb_pkg::SEB_RD_DATA && link_bits.rise_bit
                                  && !start_det && !stop_det
                                  |=> state == seb_pkg::SEB_WAIT_STOP)
      else $error("no-ack did not end read");

   a_wp_nack: assert property (byte_done && state == seb_pkg::SEB_WR_DATA && wp_sync[1]
                               && !start_det && !stop_det |=> !ack_en)
      else $error("protected data byte acknowledged");

   a_busy_nack: assert property (byte_done && state == seb_pkg::SEB_DEV_ADDR && prog_busy
                                 && !start_det && !stop_det |=> !ack_en)
      else $error("address acknowledged while busy");

endmodule: seb_eeprom_slave

`default_nettype wire

// file: seb_pkg.sv
/*
 * Shared constants and types for the two-wire serial memory slave.
 * Assumes a 100 MHz system clock and a 15-bit byte address space.
 */
package seb_pkg;

   localparam int unsigned CLOCK_HZ     = 100_000_000;
   // Longest self-timed program cycle, in milliseconds.
   localparam int unsigned PROG_TIME_MS = 5;
   localparam int unsigned PROG_CYCLES  = PROG_TIME_MS * (CLOCK_HZ / 1000);
   localparam int unsigned PROG_TIMER_W = 20;

   localparam int unsigned ADDR_W       = 15;
   localparam int unsigned PAGE_W       = 6;
   localparam int unsigned MEM_BYTES    = 32768;
   localparam int unsigned PAGE_BYTES   = 64;

   localparam logic [4:0]  DEV_TYPE      = 5'h14;
   localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
   localparam logic [3:0]  ACK_BIT       = 4'h8;
   localparam logic [14:0] PTR_RESET     = 15'h0000;

   typedef enum logic [2:0] {
      SEB_IDLE      = 3'h0,
      SEB_DEV_ADDR  = 3'h1,
      SEB_ADDR_HI   = 3'h2,
      SEB_ADDR_LO   = 3'h3,
      SEB_WR_DATA   = 3'h4,
      SEB_RD_DATA   = 3'h5,
      SEB_WAIT_STOP = 3'h6
   } seb_state_t;

endpackage: seb_pkg

// file: seb_bit_if.sv
/*
 * Carrier for bits captured on the serial clock and handed to the system domain.
 * Assumes the capture side holds rise_bit stable until its next toggle.
 */
`timescale 1ns/10ps
`default_nettype none

interface seb_bit_if;
   logic rise_toggle;
   logic rise_bit;
   modport capture (output rise_toggle, output rise_bit);
   modport engine  (input rise_toggle, input rise_bit);
endinterface: seb_bit_if

`default_nettype wire

// file: seb_scl_sampler.sv
/*
 * Serial clock domain: samples the data line on every rising serial clock edge.
 * Assumes the serial clock may stop between frames; nothing here needs later edges.
 */
`timescale 1ns/10ps
`default_nettype none

module seb_scl_sampler (
   input  wire logic  scl,
   input  wire logic  rst_b,
   input  wire logic  sda_i,
   seb_bit_if.capture bits
);

   // The bit is held for a whole serial period, long enough for the toggle to cross.
   always_ff @(posedge scl or negedge rst_b) begin
      if (!rst_b) begin
         bits.rise_toggle <= 1'h0;
         bits.rise_bit    <= 1'h1;
      end else begin
         bits.rise_toggle <= ~bits.rise_toggle;
         bits.rise_bit    <= sda_i;
      end
   end

endmodule: seb_scl_sampler

`default_nettype wire

// file: seb_master_model.sv
/*
 * Behavioural two-wire bus master that frames starts, bytes and stops on scl and sda.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/10ps
`default_nettype none

module seb_master_model (
   output var  logic scl,
   output var  logic sda_pull,
   input  wire logic sda
);

   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // Data moves only while scl is low and is read midway through the high phase,
   // after the slave's delayed answer has settled.
   task automatic put_bit(input logic b, output logic seen);
      #10 sda_pull = ~b;
      #30 scl = 1'b1;
      #20 seen = sda;
      #20 scl = 1'b0;
   endtask: put_bit

   task automatic start_cond;
      #13 sda_pull = 1'b0;
      #30 scl = 1'b1;
      #20 sda_pull = 1'b1;
      #40 scl = 1'b0;
   endtask: start_cond

   // The clock then stands high, and the bus is left free before the next frame.
   task automatic stop_cond;
      #10 sda_pull = 1'b1;
      #30 scl = 1'b1;
      #20 sda_pull = 1'b0;
      #100;
   endtask: stop_cond

   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(d[i], s);
      put_bit(1'b1, s);
      ack = ~s;
   endtask: send_byte

   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
      put_bit(~ack, s);
   endtask: recv_byte

endmodule: seb_master_model

`default_nettype wire

// file: seb_eeprom_slave_bench.sv
/*
 * Self-checking bench for the serial memory slave, driving it through the master model.
 * Assumes the design package and the master model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module seb_eeprom_slave_bench;

   localparam int unsigned PROG   = 200;
   localparam int unsigned LIMIT  = 60000;
   localparam logic [7:0]  DEV_WR = {seb_pkg::DEV_TYPE, 3'h0};
   localparam logic [7:0]  DEV_RD = {seb_pkg::DEV_TYPE, 3'h1};

   logic      clock;
   logic      rst_b;
   logic      wp;
   logic      strap_lo;
   logic      strap_hi;
   wire logic scl;
   wire logic sda;
   wire logic sda_pull;
   wire logic sda_o;
   wire logic sda_oe;
   wire logic prog_busy;
   int        err_count;
   int        samples_checked;
   int        busy_len;
   int        cycles;
   logic      k;

   assign sda = ~(sda_pull | (sda_oe & ~sda_o));

   seb_master_model mdl (
      .scl      (scl),
      .sda_pull (sda_pull),
      .sda      (sda)
   );

   seb_eeprom_slave #(
      .PROG_CYCLES (PROG)
   ) dut (
      .clock             (clock),
      .rst_b             (rst_b),
      .scl               (scl),
      .sda_i             (sda),
      .wp                (wp),
      .select_strap_low  (strap_lo),
      .select_strap_high (strap_hi),
      .sda_o             (sda_o),
      .sda_oe            (sda_oe),
      .prog_busy         (prog_busy)
   );

   initial clock = 1'b0;
   always #5 clock = ~clock;

   ////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask: final_report

   task automatic check_ack(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s: got %b expected %b", $time, what, got, exp);
      end
   endtask: check_ack

   task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask: check_val

   task automatic open_frame(input logic [7:0] a, input logic exp_ack);
      logic got;
      mdl.start_cond();
      mdl.send_byte(a, got);
      check_ack(got, exp_ack, "address acknowledge");
   endtask: open_frame

   task automatic put_byte(input logic [7:0] d, input logic exp_ack);
      logic got;
      mdl.send_byte(d, got);
      check_ack(got, exp_ack, "byte acknowledge");
   endtask: put_byte

   task automatic get_byte(input logic ack, input logic [7:0] exp);
      logic [7:0] d;
      mdl.recv_byte(ack, d);
      check_val({8'h00, d}, {8'h00, exp}, "read data");
   endtask: get_byte

   // Polls once while busy, then waits out the cycle and polls again.
   task automatic finish_write;
      int n;
      busy_len = 0;
      mdl.stop_cond();
      check_ack(prog_busy, 1'b1, "program cycle running");
      open_frame(DEV_WR, 1'b0);
      mdl.stop_cond();
      n = 0;
      while (prog_busy !== 1'b0 && n < 1000) begin
         @(negedge clock);
         n++;
      end
      check_val(busy_len[15:0], 16'(PROG), "program cycle length");
      open_frame(DEV_WR, 1'b1);
      mdl.stop_cond();
   endtask: finish_write

   // Page started at 0x3E with 66 bytes; the last two overwrite the first two.
   function automatic logic [7:0] page_val(input int a);
      int j;
      j = (a + 2) % 64;
      if (j < 2)
         j = j + 64;
      return 8'h10 + 8'(j);
   endfunction: page_val

   ////////////////////////////////////////////////////////////
   always @(negedge clock) begin
      if (prog_busy === 1'b1) begin
         busy_len = busy_len + 1;
         check_ack(sda_oe, 1'b0, "data line released while busy");
      end
   end

   always @(posedge clock) begin
      cycles = cycles + 1;
      if (cycles == LIMIT) begin
         err_count++;
         $display("[FAIL] %0t run exceeded its cycle limit", $time);
         final_report();
      end
   end

   initial begin
      err_count = 0;
      samples_checked = 0;
      busy_len = 0;
      cycles = 0;
      rst_b = 1'b0;
      wp = 1'b0;
      strap_lo = 1'b0;
      strap_hi = 1'b0;
      repeat (8) @(negedge clock);
      rst_b = 1'b1;
      repeat (8) @(negedge clock);
      for (int s = 0; s < 4; s++) begin
         @(negedge clock);
         {strap_hi, strap_lo} = 2'(s);
         repeat (4) @(negedge clock);
         open_frame({seb_pkg::DEV_TYPE, 2'(s), 1'b0}, 1'b1);
         mdl.stop_cond();
         open_frame({seb_pkg::DEV_TYPE, 2'(s) ^ 2'h1, 1'b0}, 1'b0);
         mdl.stop_cond();
      end
      open_frame({5'h15, 2'h3, 1'b0}, 1'b0);
      mdl.stop_cond();
      @(negedge clock);
      {strap_hi, strap_lo} = 2'h0;
      repeat (4) @(negedge clock);
      open_frame(DEV_WR, 1'b1);
      put_byte(8'hFF, 1'b1);
      put_byte(8'hFF, 1'b1);
      put_byte(8'h5A, 1'b1);
      finish_write();
      open_frame(DEV_WR, 1'b1);
      put_byte(8'h00, 1'b1);
      put_byte(8'h3E, 1'b1);
      for (int n = 0; n < 66; n++) put_byte(8'h10 + 8'(n), 1'b1);
      finish_write();
      @(negedge clock);
      wp = 1'b1;
      repeat (4) @(negedge clock);
      open_frame(DEV_WR, 1'b1);
      put_byte(8'h00, 1'b1);
      put_byte(8'h05, 1'b1);
      put_byte(8'hEE, 1'b0);
      mdl.stop_cond();
      check_ack(prog_busy, 1'b0, "no program cycle when protected");
      @(negedge clock);
      wp = 1'b0;
      repeat (4) @(negedge clock);
      open_frame(DEV_WR, 1'b1);
      put_byte(8'hFF, 1'b1);
      put_byte(8'hFF, 1'b1);
      open_frame(DEV_RD, 1'b1);
      get_byte(1'b0, 8'h5A);
      get_byte(1'b0, 8'hFF);
      mdl.stop_cond();
      open_frame(DEV_RD, 1'b1);
      for (int a = 0; a < 64; a++) get_byte(a < 63, page_val(a));
      mdl.stop_cond();
      open_frame(DEV_WR, 1'b1);
      put_byte(8'h00, 1'b1);
      for (int b = 0; b < 3; b++) mdl.put_bit(1'b0, k);
      open_frame(DEV_WR, 1'b1);
      put_byte(8'h00, 1'b1);
      put_byte(8'h07, 1'b1);
      open_frame(DEV_RD, 1'b1);
      get_byte(1'b0, page_val(7));
      mdl.stop_cond();
      final_report();
   end

endmodule: seb_eeprom_slave_bench

`default_nettype wire
